/* File: hdl/eil_pkg.sv */
// Package of constants, states and carriers for the encrypted image loader
`default_nettype none
package eil_pkg;
	localparam int KEY_W = 128;
	localparam int IMG_W = 32;
	localparam int DEC_LAT = 4;
	localparam logic [2:0] DEC_LAT_M1 = 3'h3;
	// Cycles after reset before the settings freeze; lets the synchronisers
	// fill and gives software time to store the key first
	localparam logic [3:0] SETTLE_CYC = 4'h8;
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_KEY0 = 8'h10;
	localparam logic [7:0] OFF_KEY3 = 8'h1C;
	// Control fields
	localparam int CTRL_START = 0;
	// Status fields
	localparam int ST_DONE = 0;
	localparam int ST_FAIL = 1;
	localparam int ST_IMG = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_FB = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_CHECK = 6'h02,
		S_LOAD = 6'h04,
		S_NEXT = 6'h08,
		S_DONE = 6'h10,
		S_FAIL = 6'h20
	} eil_state_t;
	// Per-image header as seen from the flash
	typedef struct packed {
		logic present;
		logic encrypted;
		logic [KEY_W-1:0] key;
	} eil_img_t;
	// Settings captured once at power-up
	typedef struct packed {
		logic dual_mode;
		logic enc_only;
		logic auto_fb;
		logic sel;
		logic key_stored;
	} eil_cfg_t;
	// AXI4-Lite write address and data carrier
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
	} eil_wr_t;
endpackage
`default_nettype wire

/* File: hdl/eil_sync.sv */
// Two-flop synchroniser for pin inputs
`default_nettype none
module eil_sync (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_d,
	output logic o_q
);
	logic meta_reg;
	// First flop feeds only the second
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= 1'b0;
			o_q <= 1'b0;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/eil_decrypt.sv */
// Image decryption stage: keyed word transform with fixed latency
`default_nettype none
module eil_decrypt
	import eil_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire logic i_enc,
	input wire logic [eil_pkg::KEY_W-1:0] i_key,
	input wire logic [eil_pkg::IMG_W-1:0] i_word,
	output logic o_valid,
	output logic [eil_pkg::IMG_W-1:0] o_word
);
	logic [DEC_LAT-1:0] vld_reg;
	logic [IMG_W-1:0] pipe_reg [DEC_LAT];
	logic [IMG_W-1:0] mask;
	// Fold the key into one word; a stand-in for the cipher core
	always_comb begin
		mask = i_key[31:0] ^ i_key[63:32] ^ i_key[95:64] ^ i_key[127:96];
	end
	// Pipeline models the cipher's fixed latency
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			vld_reg <= '0;
			for (int i = 0; i < DEC_LAT; i++) begin
				pipe_reg[i] <= '0;
			end
		end else begin
			vld_reg <= {vld_reg[DEC_LAT-2:0], i_valid};
			pipe_reg[0] <= i_enc ? (i_word ^ mask) : i_word;
			for (int i = 1; i < DEC_LAT; i++) begin
				pipe_reg[i] <= pipe_reg[i-1];
			end
		end
	end
	assign o_valid = vld_reg[DEC_LAT-1];
	assign o_word = pipe_reg[DEC_LAT-1];
endmodule
`default_nettype wire

/* File: hdl/eil_loader.sv */
// Power-up image selection loader with AXI4-Lite status and key access
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module eil_loader
	import eil_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire eil_pkg::eil_img_t i_primary_image_region,
	input wire eil_pkg::eil_img_t i_secondary_image_region,
	input wire logic [eil_pkg::IMG_W-1:0] i_img_word,
	input wire logic i_dual_mode,
	input wire logic i_enc_only,
	input wire logic i_auto_fb,
	input wire logic i_sel_pin,
	output logic o_done,
	output logic o_fail,
	output logic o_image,
	output logic o_cfg_valid,
	output logic [eil_pkg::IMG_W-1:0] o_cfg_word,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	eil_state_t state_reg, state_next;
	eil_cfg_t cfg_reg;
	logic [KEY_W-1:0] key_reg;
	logic key_valid_reg;
	logic start_reg;
	logic [3:0] settle_cnt_reg;
	logic cur_img_reg;
	logic tried_other_reg;
	logic [2:0] lat_cnt_reg;
	logic sel_sync, dual_sync, enc_sync, fb_sync;
	logic img_ok;
	eil_img_t cur_hdr;
	logic aw_hold_reg, w_hold_reg;
	eil_wr_t wr_reg;
	logic [3:0] wstrb_reg;
	logic dec_valid;
	logic [IMG_W-1:0] dec_word;

	// Pins cross from outside the clock domain
	eil_sync u_sync_sel (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_d(i_sel_pin), .o_q(sel_sync));
	eil_sync u_sync_dual (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_d(i_dual_mode), .o_q(dual_sync));
	eil_sync u_sync_enc (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_d(i_enc_only), .o_q(enc_sync));
	eil_sync u_sync_fb (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_d(i_auto_fb), .o_q(fb_sync));

	// Header of the image now under test
	assign cur_hdr = cur_img_reg ? i_secondary_image_region
		: i_primary_image_region;

	// Image acceptance check
	always_comb begin
		img_ok = cur_hdr.present;
		if (cur_hdr.encrypted) begin
			// Keyless or mismatched key cannot decrypt
			img_ok = img_ok && cfg_reg.key_stored
				&& (cur_hdr.key == key_reg);
		end else if (cfg_reg.enc_only) begin
			img_ok = 1'b0;
		end
	end

	// Next-state logic of the load sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (start_reg) begin
					state_next = S_CHECK;
				end
			end
			S_CHECK: begin
				if (img_ok) begin
					state_next = S_LOAD;
				end else begin
					state_next = S_NEXT;
				end
			end
			S_LOAD: begin
				if (lat_cnt_reg == DEC_LAT_M1) begin
					state_next = S_DONE;
				end
			end
			S_NEXT: begin
				// Fallback only once, both directions
				if (cfg_reg.dual_mode && cfg_reg.auto_fb
					&& !tried_other_reg) begin
					state_next = S_CHECK;
				end else begin
					state_next = S_FAIL;
				end
			end
			S_DONE: state_next = S_DONE;
			S_FAIL: state_next = S_FAIL;
			default: state_next = S_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Settle window after reset; a start any sooner would freeze the
	// synchronisers' reset zeros and miss a key stored just after reset
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			settle_cnt_reg <= '0;
		end else if (settle_cnt_reg != SETTLE_CYC) begin
			settle_cnt_reg <= settle_cnt_reg + 4'h1;
		end
	end

	// Start once the settle window is over
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_reg <= 1'b0;
		end else begin
			start_reg <= (settle_cnt_reg == SETTLE_CYC);
		end
	end

	// Settings captured once, at the start of the sequence
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_reg <= '0;
		end else if (state_reg == S_IDLE && start_reg) begin
			cfg_reg.dual_mode <= dual_sync;
			cfg_reg.enc_only <= enc_sync;
			cfg_reg.auto_fb <= fb_sync;
			cfg_reg.sel <= sel_sync;
			cfg_reg.key_stored <= key_valid_reg;
		end
	end

	// Image choice and fallback tracking
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur_img_reg <= 1'b0;
			tried_other_reg <= 1'b0;
		end else if (state_reg == S_IDLE && start_reg) begin
			// Single mode or no fallback: image 0 only
			cur_img_reg <= dual_sync && fb_sync && sel_sync;
		end else if (state_reg == S_NEXT && state_next == S_CHECK) begin
			cur_img_reg <= !cur_img_reg;
			tried_other_reg <= 1'b1;
		end
	end

	// Decrypt latency count while loading
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lat_cnt_reg <= '0;
		end else if (state_reg == S_LOAD) begin
			lat_cnt_reg <= lat_cnt_reg + 3'h1;
		end else begin
			lat_cnt_reg <= '0;
		end
	end

	// Decrypt stream while loading
	eil_decrypt u_dec (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_valid(state_reg == S_LOAD || state_reg == S_DONE),
		.i_enc(cur_hdr.encrypted),
		.i_key(key_reg),
		.i_word(i_img_word),
		.o_valid(dec_valid),
		.o_word(dec_word)
	);

	// Outputs of the loader
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cfg_valid <= 1'b0;
			o_cfg_word <= '0;
		end else begin
			o_cfg_valid <= dec_valid && state_reg == S_DONE;
			o_cfg_word <= dec_word;
		end
	end
	assign o_done = (state_reg == S_DONE);
	assign o_fail = (state_reg == S_FAIL);
	assign o_image = cur_img_reg;

	// AXI write: address and data taken in either order
	assign o_awready = !aw_hold_reg && !o_bvalid;
	assign o_wready = !w_hold_reg && !o_bvalid;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			wr_reg <= '0;
			wstrb_reg <= '0;
		end else if (aw_hold_reg && w_hold_reg) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_hold_reg <= 1'b1;
				wr_reg.addr <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_hold_reg <= 1'b1;
				wr_reg.data <= i_wdata;
				wstrb_reg <= i_wstrb;
			end
		end
	end

	// Key store: word writes with byte strobes; key locks once loading
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			key_reg <= '0;
			key_valid_reg <= 1'b0;
		end else if (aw_hold_reg && w_hold_reg && state_reg == S_IDLE
			&& wr_reg.addr[1:0] == 2'h0
			&& wr_reg.addr >= OFF_KEY0 && wr_reg.addr <= OFF_KEY3) begin
			for (int b = 0; b < 4; b++) begin
				if (wstrb_reg[b]) begin
					key_reg[{wr_reg.addr[3:2], 5'h00} + 7'(b * 8) +: 8]
						<= wr_reg.data[b*8 +: 8];
				end
			end
			key_valid_reg <= 1'b1;
		end
	end

	// Write response; unmapped or late key writes get SLVERR
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end else if (aw_hold_reg && w_hold_reg) begin
			o_bvalid <= 1'b1;
			o_bresp <= (wr_reg.addr >= OFF_KEY0 && wr_reg.addr <= OFF_KEY3
				&& wr_reg.addr[1:0] == 2'h0 && state_reg == S_IDLE)
				? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// AXI read: status, and control giving the key-stored flag; key stays unreadable for security
	assign o_arready = !o_rvalid;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rdata <= '0;
			o_rresp <= RESP_OKAY;
			if (i_araddr == OFF_STATUS) begin
				o_rdata[ST_DONE] <= o_done;
				o_rdata[ST_FAIL] <= o_fail;
				o_rdata[ST_IMG] <= cur_img_reg;
				o_rdata[ST_BUSY] <= !o_done && !o_fail;
				o_rdata[ST_FB] <= tried_other_reg;
			end else if (i_araddr == OFF_CTRL) begin
				o_rdata[CTRL_START] <= key_valid_reg;
			end else begin
				o_rresp <= RESP_SLVERR;
			end
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: dv/eil_loader_chk.sv */
// Checker of image selection outcomes at the loader ports
`default_nettype none
module eil_loader_chk
	import eil_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire eil_pkg::eil_img_t i_primary_image_region,
	input wire eil_pkg::eil_img_t i_secondary_image_region,
	input wire logic i_dual_mode,
	input wire logic i_enc_only,
	input wire logic i_auto_fb,
	input wire logic i_sel_pin,
	input wire logic o_done,
	input wire logic o_fail,
	input wire logic o_image
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// Header of the image that was loaded
	wire logic enc_loaded = o_image ? i_secondary_image_region.encrypted
		: i_primary_image_region.encrypted;
	wire logic both_plain = !i_primary_image_region.encrypted
		&& !i_secondary_image_region.encrypted;
	// A verdict must follow every reset release within a bounded time
	sequence s_release;
		$rose(i_rst_n);
	endsequence
	sequence s_verdict;
		##[1:80] (o_done || o_fail);
	endsequence
	a_verdict_bounded: assert property (
		s_release |-> s_verdict)
		else $error("no verdict after reset release");
	a_never_both: assert property (!(o_done && o_fail))
		else $error("done and fail together");
	a_fail_holds: assert property (o_fail |=> o_fail)
		else $error("fail dropped");
	a_done_holds: assert property (
		o_done |=> o_done && $stable(o_image))
		else $error("loaded image changed");
	a_single_img0: assert property (
		o_done && !i_dual_mode |-> !o_image)
		else $error("single mode loaded image 1");
	a_nofb_img0: assert property (
		o_done && !i_auto_fb |-> !o_image)
		else $error("image 1 loaded with fallback off");
	a_enc_only: assert property (
		o_done && i_enc_only |-> enc_loaded)
		else $error("plain image loaded under enforcement");
	a_pin_picks: assert property (
		o_done && i_dual_mode && i_auto_fb && !i_enc_only && both_plain
		|-> o_image == i_sel_pin)
		else $error("select pin not obeyed");
	// Image 1 against a low select pin can only come from a fallback
	a_fallback_gated: assert property (
		o_done && o_image && !i_sel_pin |-> i_dual_mode && i_auto_fb)
		else $error("image 1 loaded without fallback");
endmodule
bind eil_loader eil_loader_chk eil_loader_chk_i (.i_mclk(i_mclk),
	.i_rst_n(i_rst_n), .i_primary_image_region(i_primary_image_region),
	.i_secondary_image_region(i_secondary_image_region),
	.i_dual_mode(i_dual_mode), .i_enc_only(i_enc_only),
	.i_auto_fb(i_auto_fb), .i_sel_pin(i_sel_pin), .o_done(o_done),
	.o_fail(o_fail), .o_image(o_image));
`default_nettype wire

/* File: dv/eil_flash_model.sv */
// Flash model serving both image headers and a data stream
`default_nettype none
module eil_flash_model
	import eil_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_mode,
	input wire logic [31:0] i_key_lo,
	output wire eil_pkg::eil_img_t o_primary,
	output wire eil_pkg::eil_img_t o_secondary,
	output var logic [31:0] o_word
);
	wire logic [KEY_W-1:0] key_ok = {96'h0, i_key_lo};
	// Mode is {enc0,match0,enc1,match1}; mismatch inverts the key
	assign o_primary = '{1'b1, i_mode[3],
		i_mode[2] ? key_ok : ~key_ok};
	assign o_secondary = '{1'b1, i_mode[1], i_mode[0] ? key_ok : ~key_ok};
	// Word changes every cycle so a stale word never looks valid
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_word <= 32'h0;
		end else begin
			o_word <= o_word + 32'h9E3779B9;
		end
	end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Testbench walking the image outcome table over reset cycles
`default_nettype none
module testbench import eil_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk, i_rst_n, i_dual_mode, i_enc_only, i_auto_fb, i_sel_pin;
	logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic o_done, o_fail, o_image, o_cfg_valid, o_awready, o_wready;
	logic o_bvalid, o_arready, o_rvalid;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, o_cfg_word, word, d;
	logic [31:0] w1, m;
	logic fbx;
	logic [3:0] mode;
	logic [1:0] o_bresp, o_rresp, r;
	logic [11:0] c;
	eil_img_t prim, sec;
	int fail_count, n_checks, k, n;
	// Arbitrary low key word; upper key bits stay zero
	localparam logic [31:0] KEY_LO = 32'hC0DE5EED;
	// Step of the flash model's data word per cycle
	localparam logic [31:0] WORD_STEP = 32'h9E3779B9;
	// {dual,enforce,fb,sel} {keyw,enc0,match0,0} {enc1,match1,fail,img}
	localparam logic [11:0] CASES [17] = '{12'h300, 12'h280, 12'h682,
		12'h642, 12'h7E0, 12'h6C2, 12'hA00, 12'hB01, 12'hA41, 12'hBE1,
		12'hFE4, 12'hE4F, 12'hFE8, 12'hECD, 12'h900, 12'h842, 12'h8C2};
	eil_flash_model eil_flash_model_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_mode(mode), .i_key_lo(KEY_LO), .o_primary(prim),
		.o_secondary(sec), .o_word(word));
	eil_loader eil_loader_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_primary_image_region(prim), .i_secondary_image_region(sec),
		.i_img_word(word), .i_dual_mode(i_dual_mode),
		.i_enc_only(i_enc_only), .i_auto_fb(i_auto_fb),
		.i_sel_pin(i_sel_pin), .o_done(o_done), .o_fail(o_fail),
		.o_image(o_image), .o_cfg_valid(o_cfg_valid),
		.o_cfg_word(o_cfg_word), .i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
		.i_wstrb(4'hF), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.o_rvalid(o_rvalid), .i_rready(i_rready));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Ready is judged at the falling edge, where it is settled
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		@(posedge i_mclk);
		i_awaddr <= a;
		i_wdata <= v;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		while ((aw || w) && n < 40) begin
			@(negedge i_mclk);
			aw = aw && !o_awready;
			w = w && !o_wready;
			n++;
			@(posedge i_mclk);
			i_awvalid <= aw;
			i_wvalid <= w;
		end
		do begin
			@(negedge i_mclk);
			n++;
		end while (!o_bvalid && n < 80);
		r = o_bresp;
		@(posedge i_mclk);
		i_bready <= 1'b0;
		if (n >= 80) fail_count++;
	endtask
	task automatic axi_read(input logic [7:0] a);
		@(posedge i_mclk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		n = 0;
		do begin
			@(negedge i_mclk);
			n++;
		end while (!o_arready && n < 40);
		@(posedge i_mclk);
		i_arvalid <= 1'b0;
		do begin
			@(negedge i_mclk);
			n++;
		end while (!o_rvalid && n < 80);
		d = o_rdata;
		r = o_rresp;
		@(posedge i_mclk);
		i_rready <= 1'b0;
		if (n >= 80) fail_count++;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Clock of 5 ns period
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	// Cut a hang short well past the expected run length
	initial begin
		#50000;
		fail_count++;
		tally_and_finish();
	end
	// Each case: settings during reset, optional key, verdict, status
	initial begin
		{i_rst_n, i_dual_mode, i_enc_only, i_auto_fb, i_sel_pin} = 5'h0;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
		{i_awaddr, i_araddr, i_wdata, mode} = 52'h0;
		for (k = 0; k < 17; k++) begin
			c = CASES[k];
			@(posedge i_mclk);
			i_rst_n <= 1'b0;
			{i_dual_mode, i_enc_only, i_auto_fb, i_sel_pin} <= c[11:8];
			mode <= {c[6:5], c[3:2]};
			repeat (16) @(posedge i_mclk);
			i_rst_n <= 1'b1;
			if (c[7]) begin
				axi_write(OFF_KEY0, KEY_LO);
				check({30'h0, r}, {30'h0, RESP_OKAY});
			end
			n = 0;
			do begin
				@(negedge i_mclk);
				n++;
			end while (!(o_done || o_fail) && n < 100);
			check({29'h0, o_done, o_fail, o_image},
				{29'h0, ~c[1], c[1], c[0]});
			// Loaded words keep the flash step once the key mask is undone
			n = 0;
			while (!c[1] && !o_cfg_valid && n < 20) begin
				@(negedge i_mclk);
				n++;
			end
			check({31'h0, o_cfg_valid}, {31'h0, ~c[1]});
			w1 = o_cfg_word;
			@(negedge i_mclk);
			m = (c[0] ? c[3] : c[6]) ? KEY_LO : 32'h0;
			if (!c[1]) begin
				check((o_cfg_word ^ m) - (w1 ^ m), WORD_STEP);
			end
			// Fallback used: dual with fallback on, and a failure or a swap
			fbx = c[11] && c[9] && (c[1] || (c[0] != c[8]));
			axi_read(OFF_STATUS);
			check(d & 32'h1F,
				{27'h0, fbx, 1'b0, c[0], c[1], ~c[1]});
			axi_read(OFF_CTRL);
			check(d & 32'h1, {31'h0, c[7]});
			$display("test %0d done", k);
		end
		// Late key write and an unmapped read are both refused
		axi_write(OFF_KEY3, 32'h1);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		axi_read(8'h40);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		$display("test refusals done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
